// >>> hw/ps_pkg.sv
// Purpose: Shared constants and types of the program sequencer
// Assumes: APB register window, byte address = index * 4
// Notes: Vector and table constants sized to the widest counter
package ps_pkg;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int PHASES = 4;
   localparam logic [1:0] LAST_PHASE = 2'h3;
   localparam logic [3:0] PHASE_RST = 4'h1;
   // ----------------------------------------
   // Address counter
   // ----------------------------------------
   localparam int ADDR_MAX_W = 13;
   localparam logic [12:0] VEC_RESET = 13'h0000;
   localparam logic [12:0] VEC_EXT = 13'h0004;
   localparam logic [12:0] VEC_T0 = 13'h0008;
   localparam logic [12:0] VEC_T1 = 13'h000c;
   localparam int PAGE_BITS = 8;
   // ----------------------------------------
   // Register indices and fields
   // ----------------------------------------
   localparam logic [7:0] IDX_CNT_LO = 8'h06;
   localparam logic [7:0] IDX_TBL_PTR = 8'h07;
   localparam logic [7:0] IDX_TBL_HI = 8'h08;
   localparam logic [7:0] IDX_CTRL = 8'h09;
   localparam logic [7:0] IDX_STAT = 8'h0a;
   localparam int INT_EXT = 0;
   localparam int INT_T0 = 1;
   localparam int INT_T1 = 2;
   localparam int N_INT = 3;
   localparam int STAT_LVL_POS = 4;
   localparam int STAT_PC_POS = 16;
   localparam logic [7:0] TBL_PTR_RST = 8'h00;
   localparam logic [2:0] CTRL_RST = 3'h0;
   localparam logic [2:0] FLAG_RST = 3'h0;
   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [2:0] {
      OP_NONE, OP_JUMP, OP_CALL, OP_SUB_RET, OP_INT_RET, OP_SKIP, OP_TRDC, OP_TRDL
   } ps_op_t;
   typedef enum logic {MODE_RUN, MODE_TABLE} ps_mode_t;
   typedef struct packed {
      ps_op_t op;
      logic [12:0] target;
   } ps_cmd_t;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [9:0] paddr;
      logic [31:0] pwdata;
   } ps_apb_req_t;
   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } ps_apb_rsp_t;
endpackage : ps_pkg

// >>> hw/ps_phase_gen.sv
// Purpose: Four-phase instruction cycle timing
// Assumes: Synchronous active-high reset
// Notes: Phase 0 follows reset
`timescale 1ns/100ps
module ps_phase_gen (
   input wire logic clk_in,           // System clock
   input wire logic rst_in,           // Synchronous reset
   output logic [3:0] phase_out,      // One-hot phase
   output logic cycle_end_out         // Last phase of cycle
);
   typedef struct packed {
      logic [1:0] cnt;
      logic [3:0] ph;
   } ps_phase_state_t;
   ps_phase_state_t st_reg;
   ps_phase_state_t st_next;

   always_comb begin
      st_next = st_reg;
      st_next.cnt = st_reg.cnt + 2'h1;
      st_next.ph = {st_reg.ph[2:0], st_reg.ph[3]};
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         st_reg <= '{cnt: 2'h0, ph: ps_pkg::PHASE_RST};
      end else begin
         st_reg <= st_next;
      end
   end

   assign phase_out = st_reg.ph;
   assign cycle_end_out = (st_reg.cnt == ps_pkg::LAST_PHASE);

   property p_cycle_len;
      @(posedge clk_in) disable iff (rst_in)
      cycle_end_out |=> !cycle_end_out [*3] ##1 cycle_end_out;
   endproperty
   a_cycle_len: assert property (p_cycle_len) else $error("cycle not 4 clocks");
   property p_phase_onehot;
      @(posedge clk_in) disable iff (rst_in)
      $onehot(phase_out) && (cycle_end_out == phase_out[3]);
   endproperty
   a_phase_onehot: assert property (p_phase_onehot) else $error("phase overlap");
endmodule : ps_phase_gen

// >>> hw/ps_return_stack.sv
// Purpose: Hardware return stack; entries hidden from software, level readable in the status register
// Assumes: Push and pop never in the same cycle
// Notes: Push when full drops the oldest entry
`timescale 1ns/100ps
module ps_return_stack #(
   parameter int DEPTH = 8,
   parameter int W = 13
) (
   input wire logic clk_in,           // System clock
   input wire logic rst_in,           // Synchronous reset
   input wire logic push_in,          // Push request
   input wire logic pop_in,           // Pop request
   input wire logic [W-1:0] data_in,  // Pushed address
   output logic [W-1:0] top_out,      // Most recent entry
   output logic full_out,             // All levels used
   output logic [3:0] level_out       // Levels in use
);
   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] ent;
      logic [3:0] lvl;
   } ps_stk_state_t;
   ps_stk_state_t st_reg;
   ps_stk_state_t st_next;

   always_comb begin
      st_next = st_reg;
      if (push_in) begin
         st_next.ent = {st_reg.ent[DEPTH-2:0], data_in};
         if (!full_out) begin
            st_next.lvl = st_reg.lvl + 4'h1;
         end
      end else if (pop_in) begin
         st_next.ent = {data_in, st_reg.ent[DEPTH-1:1]};
         if (st_reg.lvl != 4'h0) begin
            st_next.lvl = st_reg.lvl - 4'h1;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign top_out = st_reg.ent[0];
   assign full_out = (st_reg.lvl == 4'(DEPTH));
   assign level_out = st_reg.lvl;

   property p_push_top;
      @(posedge clk_in) disable iff (rst_in)
      push_in |=> (top_out == $past(data_in)) && (level_out != 4'h0);
   endproperty
   a_push_top: assert property (p_push_top) else $error("push lost");
   property p_full_keep;
      @(posedge clk_in) disable iff (rst_in)
      (full_out && push_in) |=> full_out && (level_out == 4'(DEPTH));
   endproperty
   a_full_keep: assert property (p_full_keep) else $error("overflow bad");
endmodule : ps_return_stack

// >>> hw/ps_sequencer.sv
// Purpose: Program sequencer: fetch, counter, stack, table reads
// Assumes: ROM answers within three clocks; commands valid at phase 3
// Notes: Registers on APB, zero wait states
//
// The APB register port is this design's own decision.
`timescale 1ns/100ps
// Contract
// - Four phases per instruction cycle, each cycle exactly four clocks.
// - Next word fetched while current executes, one instruction per cycle.
// - Counter-changing instructions take two cycles via a dummy cycle.
// - Counter width is a build parameter of 10 to 13 bits.
// - Counter increments by one after every instruction fetch.
// - True skip discards fetched word, dummy cycle, continue at address plus two.
// - Write to low-byte register at 06H replaces counter low byte.
// - Reset loads counter with zero; execution starts at 000H.
// - Enabled external interrupt with room on stack vectors to 004H.
// - Enabled timer 0 overflow with room on stack vectors to 008H.
// - Enabled timer 1 overflow with room on stack vectors to 00CH.
// - Table address: pointer low byte, current page or all-ones page.
// - Table read sends low byte out, upper bits to high-byte register 08H.
// - Table pointer is an 8-bit read/write register at 07H.
// - Each table read takes two instruction cycles.
// - Stack depth parameter 2, 4 or 8; stack invisible to software; the design shows its level in status register 0AH.
// - Call and interrupt push counter; returns restore it.
// - Reset leaves the stack pointer at the empty top.
// - Interrupt on full stack stays flagged until a return pops.
// - Jumps and calls load the counter with the instruction target.
// - Call on full stack loses the oldest return address.
module ps_sequencer #(
   parameter int PC_W = 13,
   parameter int STK_DEPTH = 8,
   parameter int ROM_W = 16,
   parameter bit HAS_T1 = 1'b1
) (
   input wire logic CORE_CLK_IN,                  // System clock
   input wire logic SYS_RST_IN,                   // Sync reset, high
   input wire ps_pkg::ps_apb_req_t APB_REQ_IN,    // APB request
   output ps_pkg::ps_apb_rsp_t APB_RSP_OUT,       // APB response
   input wire ps_pkg::ps_cmd_t CMD_IN,            // Decoder command
   input wire logic EXT_INT_N_IN,                 // External interrupt, low
   input wire logic TMR0_OVF_IN,                  // Timer 0 overflow pulse
   input wire logic TMR1_OVF_IN,                  // Timer 1 overflow pulse
   output logic [PC_W-1:0] ROM_ADDR_OUT,          // Program ROM address
   input wire logic [ROM_W-1:0] ROM_DATA_IN,      // Program ROM word
   output logic [3:0] PHASE_OUT,                  // One-hot phase
   output logic CYCLE_END_OUT,                    // Last phase pulse
   output logic [ROM_W-1:0] INSTR_OUT,            // Word in execution
   output logic INSTR_VALID_OUT,                  // Not a dummy cycle
   output logic [7:0] TBL_DATA_OUT,               // Table low byte
   output logic TBL_WR_OUT,                       // Table byte strobe
   output logic INT_ACK_OUT                       // Interrupt taken pulse
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic [PC_W-1:0] pc;
      logic [ROM_W-1:0] ir;
      logic ir_valid;
      ps_pkg::ps_mode_t mode;
      logic [PC_W-1:0] tbl_addr;
      logic [7:0] tbl_ptr;
      logic [ROM_W-9:0] tbl_hi;
      logic [7:0] tbl_data;
      logic tbl_wr;
      logic lo_pend;
      logic [7:0] lo_val;
      logic [2:0] int_en;
      logic [2:0] int_flag;
      logic int_ack;
      logic ext_n_prev;
      logic [PC_W-1:0] rom_addr;
      logic [31:0] prdata;
      logic pslverr;
   } ps_seq_state_t;

   localparam ps_seq_state_t ST_RST = '{
      pc: ps_pkg::VEC_RESET[PC_W-1:0],
      ir: '0,
      ir_valid: 1'b0,
      mode: ps_pkg::MODE_RUN,
      tbl_addr: '0,
      tbl_ptr: ps_pkg::TBL_PTR_RST,
      tbl_hi: '0,
      tbl_data: 8'h00,
      tbl_wr: 1'b0,
      lo_pend: 1'b0,
      lo_val: 8'h00,
      int_en: ps_pkg::CTRL_RST,
      int_flag: ps_pkg::FLAG_RST,
      int_ack: 1'b0,
      ext_n_prev: 1'b1,
      rom_addr: ps_pkg::VEC_RESET[PC_W-1:0],
      prdata: 32'h0000_0000,
      pslverr: 1'b0
   };

   ps_seq_state_t st_reg;
   ps_seq_state_t st_next;

   logic cyc_end;
   logic exec_valid;
   ps_pkg::ps_op_t cmd_op;
   logic [2:0] int_pend;
   logic [2:0] int_events;
   logic [2:0] ack_vec;
   logic [PC_W-1:0] int_vec;
   logic int_grant;
   logic stk_push;
   logic stk_pop;
   logic [PC_W-1:0] stk_top;
   logic stk_full;
   logic [3:0] stk_level;
   logic apb_setup;
   logic apb_write;

   function automatic logic [7:0] reg_index(input logic [9:0] addr);
      return addr[9:2];
   endfunction : reg_index

   // ----------------------------------------
   // Phase timing and return stack
   // ----------------------------------------
   ps_phase_gen u_phase (
      .clk_in(CORE_CLK_IN),
      .rst_in(SYS_RST_IN),
      .phase_out(PHASE_OUT),
      .cycle_end_out(cyc_end)
   );

   ps_return_stack #(
      .DEPTH(STK_DEPTH),
      .W(PC_W)
   ) u_stack (
      .clk_in(CORE_CLK_IN),
      .rst_in(SYS_RST_IN),
      .push_in(stk_push),
      .pop_in(stk_pop),
      .data_in(st_reg.pc),
      .top_out(stk_top),
      .full_out(stk_full),
      .level_out(stk_level)
   );

   // ----------------------------------------
   // Interrupt selection
   // ----------------------------------------
   assign exec_valid = st_reg.ir_valid && (st_reg.mode == ps_pkg::MODE_RUN);
   assign cmd_op = exec_valid ? CMD_IN.op : ps_pkg::OP_NONE;
   assign int_pend = st_reg.int_flag & st_reg.int_en;
   assign int_grant = (int_pend != 3'h0) && !stk_full;
   assign int_events = {TMR1_OVF_IN & HAS_T1, TMR0_OVF_IN,
                        st_reg.ext_n_prev & ~EXT_INT_N_IN};

   always_comb begin
      ack_vec = 3'h0;
      int_vec = ps_pkg::VEC_T1[PC_W-1:0];
      if (int_pend[ps_pkg::INT_EXT]) begin
         ack_vec[ps_pkg::INT_EXT] = 1'b1;
         int_vec = ps_pkg::VEC_EXT[PC_W-1:0];
      end else if (int_pend[ps_pkg::INT_T0]) begin
         ack_vec[ps_pkg::INT_T0] = 1'b1;
         int_vec = ps_pkg::VEC_T0[PC_W-1:0];
      end else if (int_pend[ps_pkg::INT_T1]) begin
         ack_vec[ps_pkg::INT_T1] = 1'b1;
      end
   end

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   assign apb_setup = APB_REQ_IN.psel && !APB_REQ_IN.penable;
   assign apb_write = APB_REQ_IN.psel && APB_REQ_IN.penable && APB_REQ_IN.pwrite;

   always_comb begin
      st_next = st_reg;
      st_next.tbl_wr = 1'b0;
      st_next.int_ack = 1'b0;
      st_next.ext_n_prev = EXT_INT_N_IN;
      stk_push = 1'b0;
      stk_pop = 1'b0;
      if (cyc_end) begin
         unique case (st_reg.mode)
            ps_pkg::MODE_TABLE: begin
               st_next.tbl_data = ROM_DATA_IN[7:0];
               st_next.tbl_hi = ROM_DATA_IN[ROM_W-1:8];
               st_next.tbl_wr = 1'b1;
               st_next.mode = ps_pkg::MODE_RUN;
            end
            ps_pkg::MODE_RUN: begin
               st_next.ir = ROM_DATA_IN;
               st_next.ir_valid = 1'b1;
               st_next.pc = st_reg.pc + 1'b1;
               unique case (cmd_op)
                  ps_pkg::OP_JUMP: begin
                     st_next.pc = CMD_IN.target[PC_W-1:0];
                     st_next.ir_valid = 1'b0;
                  end
                  ps_pkg::OP_CALL: begin
                     stk_push = 1'b1;
                     st_next.pc = CMD_IN.target[PC_W-1:0];
                     st_next.ir_valid = 1'b0;
                  end
                  ps_pkg::OP_SUB_RET, ps_pkg::OP_INT_RET: begin
                     stk_pop = 1'b1;
                     st_next.pc = stk_top;
                     st_next.ir_valid = 1'b0;
                  end
                  ps_pkg::OP_SKIP: begin
                     st_next.ir_valid = 1'b0;
                  end
                  ps_pkg::OP_TRDC: begin
                     st_next.mode = ps_pkg::MODE_TABLE;
                     st_next.tbl_addr = {st_reg.pc[PC_W-1:8], st_reg.tbl_ptr};
                  end
                  ps_pkg::OP_TRDL: begin
                     st_next.mode = ps_pkg::MODE_TABLE;
                     st_next.tbl_addr = {{(PC_W-8){1'b1}}, st_reg.tbl_ptr};
                  end
                  ps_pkg::OP_NONE: begin
                     if (st_reg.lo_pend) begin
                        st_next.pc = {st_reg.pc[PC_W-1:8], st_reg.lo_val};
                        st_next.ir_valid = 1'b0;
                        st_next.lo_pend = 1'b0;
                     end else if (int_grant) begin
                        stk_push = 1'b1;
                        st_next.pc = int_vec;
                        st_next.ir_valid = 1'b0;
                        st_next.int_ack = 1'b1;
                     end
                  end
               endcase
            end
         endcase
      end
      // Request set wins over acknowledge clear
      st_next.int_flag = (st_reg.int_flag & ~(ack_vec & {3{st_next.int_ack}}))
                         | int_events;
      // Register read data, sampled in setup phase
      if (apb_setup) begin
         st_next.pslverr = 1'b0;
         unique case (reg_index(APB_REQ_IN.paddr))
            ps_pkg::IDX_CNT_LO: st_next.prdata = 32'(st_reg.pc[7:0]);
            ps_pkg::IDX_TBL_PTR: st_next.prdata = 32'(st_reg.tbl_ptr);
            ps_pkg::IDX_TBL_HI: st_next.prdata = 32'(st_reg.tbl_hi);
            ps_pkg::IDX_CTRL: st_next.prdata = 32'(st_reg.int_en);
            ps_pkg::IDX_STAT: begin
               st_next.prdata = 32'(st_reg.int_flag)
                  | (32'(stk_level) << ps_pkg::STAT_LVL_POS)
                  | (32'(st_reg.pc) << ps_pkg::STAT_PC_POS);
            end
            default: begin
               st_next.prdata = 32'h0000_0000;
               st_next.pslverr = 1'b1;
            end
         endcase
      end
      // Register writes; later than cycle logic so a new write is kept
      if (apb_write) begin
         unique case (reg_index(APB_REQ_IN.paddr))
            ps_pkg::IDX_CNT_LO: begin
               st_next.lo_pend = 1'b1;
               st_next.lo_val = APB_REQ_IN.pwdata[7:0];
            end
            ps_pkg::IDX_TBL_PTR: st_next.tbl_ptr = APB_REQ_IN.pwdata[7:0];
            ps_pkg::IDX_CTRL: st_next.int_en = APB_REQ_IN.pwdata[2:0];
            default: st_next.tbl_ptr = st_reg.tbl_ptr;
         endcase
      end
      st_next.rom_addr = (st_next.mode == ps_pkg::MODE_TABLE) ? st_next.tbl_addr
                                                              : st_next.pc;
   end

   always_ff @(posedge CORE_CLK_IN) begin
      if (SYS_RST_IN) begin
         st_reg <= ST_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign APB_RSP_OUT.pready = 1'b1;
   assign APB_RSP_OUT.pslverr = st_reg.pslverr && APB_REQ_IN.psel && APB_REQ_IN.penable;
   assign APB_RSP_OUT.prdata = st_reg.prdata;
   assign ROM_ADDR_OUT = st_reg.rom_addr;
   assign CYCLE_END_OUT = cyc_end;
   assign INSTR_OUT = st_reg.ir;
   assign INSTR_VALID_OUT = exec_valid;
   assign TBL_DATA_OUT = st_reg.tbl_data;
   assign TBL_WR_OUT = st_reg.tbl_wr;
   assign INT_ACK_OUT = st_reg.int_ack;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   property p_pc_incr;
      @(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
      (cyc_end && st_reg.mode == ps_pkg::MODE_RUN && cmd_op == ps_pkg::OP_NONE
       && !st_reg.lo_pend && !int_grant)
      |=> st_reg.pc == PC_W'($past(st_reg.pc) + 1'b1) && INSTR_VALID_OUT;
   endproperty
   a_pc_incr: assert property (p_pc_incr) else $error("no increment");
   property p_jump;
      @(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
      (cyc_end && cmd_op == ps_pkg::OP_JUMP)
      |=> st_reg.pc == $past(CMD_IN.target[PC_W-1:0]) ##0 !INSTR_VALID_OUT [*4];
   endproperty
   a_jump: assert property (p_jump) else $error("jump wrong");
   property p_skip;
      @(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
      (cyc_end && cmd_op == ps_pkg::OP_SKIP) |=> !INSTR_VALID_OUT [*4];
   endproperty
   a_skip: assert property (p_skip) else $error("skip no dummy");
   property p_int_vec;
      @(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
      (cyc_end && st_reg.mode == ps_pkg::MODE_RUN && cmd_op == ps_pkg::OP_NONE
       && !st_reg.lo_pend && int_grant && int_pend[ps_pkg::INT_EXT])
      |=> st_reg.pc == ps_pkg::VEC_EXT[PC_W-1:0] && INT_ACK_OUT;
   endproperty
   a_int_vec: assert property (p_int_vec) else $error("ext vector wrong");
   property p_full_block;
      @(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
      (stk_full && cyc_end) |=> !INT_ACK_OUT;
   endproperty
   a_full_block: assert property (p_full_block) else $error("ack on full");
   property p_table;
      @(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
      (cyc_end && (cmd_op == ps_pkg::OP_TRDC || cmd_op == ps_pkg::OP_TRDL))
      |=> !TBL_WR_OUT [*4] ##1 TBL_WR_OUT;
   endproperty
   a_table: assert property (p_table) else $error("table not two cycles");
endmodule : ps_sequencer

// >>> verif/ps_rom_model.sv
// Purpose: Program ROM partner with a slow answer
// Assumes: Word contents follow a fixed formula of the address
// Notes: Inverted data until three clocks after an address change
`timescale 1ns/100ps
module ps_rom_model #(
   parameter int AW = 10,
   parameter int DW = 16
) (
   input wire logic clk_in,           // System clock
   input wire logic [AW-1:0] addr_in, // Fetch address
   output logic [DW-1:0] data_out     // Program word
);
   // --------------------------------
   // Slow answer
   // --------------------------------
   logic [AW-1:0] last_addr = '0;
   logic [1:0] age = 2'h0;
   logic [DW-1:0] word;
   always @(posedge clk_in) begin
      last_addr <= addr_in;
      age <= (addr_in != last_addr) ? 2'h0 : ((age == 2'h3) ? age : age + 2'h1);
   end
   assign word = DW'(32'(addr_in) * 32'd37 + 32'd11);
   assign data_out = (age >= 2'h2) ? word : ~word;
endmodule : ps_rom_model

// >>> verif/tb.sv
// Purpose: Self-checking bench of the program sequencer
// Assumes: Narrow counter and two-level stack
// Notes: Commands issued one edge before each cycle end
`timescale 1ns/100ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
   $display("ERROR %s exp %h got %h", n, e, g); end end
module tb;
   logic clk = 1'b0;
   logic rst = 1'b1;
   ps_pkg::ps_apb_req_t apb = '0;
   ps_pkg::ps_apb_rsp_t rsp;
   ps_pkg::ps_cmd_t cmd = '0;
   logic ext_n = 1'b1;
   logic t0 = 1'b0;
   logic t1 = 1'b0;
   logic [9:0] ra;
   logic [15:0] rd;
   logic [15:0] instr;
   logic [7:0] tdata;
   logic [3:0] phase;
   logic cend;
   logic ivalid;
   logic twr;
   logic iack;
   logic [31:0] r;
   logic e;
   logic [9:0] a;
   logic [9:0] pre;
   logic [15:0] w;
   int n;
   int bad_count = 0;
   int tests_run = 0;
   always #2.5 clk = ~clk;
   ps_sequencer #(.PC_W(10), .STK_DEPTH(2), .HAS_T1(1'b1)) ps_sequencer_i (
      .CORE_CLK_IN(clk), .SYS_RST_IN(rst), .APB_REQ_IN(apb), .APB_RSP_OUT(rsp),
      .CMD_IN(cmd), .EXT_INT_N_IN(ext_n), .TMR0_OVF_IN(t0), .TMR1_OVF_IN(t1),
      .ROM_ADDR_OUT(ra), .ROM_DATA_IN(rd), .PHASE_OUT(phase), .CYCLE_END_OUT(cend),
      .INSTR_OUT(instr), .INSTR_VALID_OUT(ivalid), .TBL_DATA_OUT(tdata),
      .TBL_WR_OUT(twr), .INT_ACK_OUT(iack));
   ps_rom_model #(.AW(10), .DW(16)) ps_rom_model_i (.clk_in(clk), .addr_in(ra), .data_out(rd));
   // --------------------------------
   // Helpers
   // --------------------------------
   function automatic logic [15:0] wd(input logic [9:0] x);
      return 16'(32'(x) * 32'd37 + 32'd11);
   endfunction : wd
   task automatic apb_xfer(input logic wr, input logic [9:0] ad, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk);
      apb <= '{1'b1, 1'b0, wr, ad, d};
      @(posedge clk);
      apb.penable <= 1'b1;
      do begin
         @(posedge clk);
         k++;
      end while (rsp.pready !== 1'b1 && k < 20);
      r = rsp.prdata;
      e = rsp.pslverr;
      apb <= '0;
   endtask : apb_xfer
   task automatic step(input ps_pkg::ps_op_t op, input logic [12:0] t);
      int k;
      k = 0;
      do begin
         @(negedge clk);
         k++;
      end while (phase !== 4'h4 && k < 40);
      pre = ra;
      @(posedge clk);
      cmd <= '{op, t};
      @(posedge clk);
      cmd <= '{ps_pkg::OP_NONE, 13'h0};
      @(negedge clk);
   endtask : step
   task automatic wait_ack();
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (iack !== 1'b1 && n < 40);
   endtask : wait_ack
   task automatic results();
      $display("Checks %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : results
   // --------------------------------
   // Scenarios
   // --------------------------------
   task automatic t_seq();
      for (int i = 0; i < 5; i++) begin
         `CHK("phase", 4'(1 << (i % 4)), phase)
         `CHK("cycle end", (i % 4 == 3), cend)
         @(negedge clk);
      end
      step(ps_pkg::OP_NONE, 13'h0);
      `CHK("next addr", pre + 10'h1, ra)
      `CHK("exec word", wd(pre), instr)
   endtask : t_seq
   task automatic t_xfer();
      step(ps_pkg::OP_JUMP, 13'h1ac5);
      `CHK("jump addr", 10'h2c5, ra)
      `CHK("jump dummy", 1'b0, ivalid)
      step(ps_pkg::OP_NONE, 13'h0);
      `CHK("jump word", wd(10'h2c5), instr)
      step(ps_pkg::OP_SKIP, 13'h0);
      a = pre + 10'h1;
      `CHK("skip dummy", 1'b0, ivalid)
      step(ps_pkg::OP_NONE, 13'h0);
      `CHK("skip word", wd(a), instr)
      step(ps_pkg::OP_CALL, 13'h0123);
      a = pre;
      `CHK("call addr", 10'h123, ra)
      step(ps_pkg::OP_NONE, 13'h0);
      step(ps_pkg::OP_SUB_RET, 13'h0);
      `CHK("return addr", a, ra)
   endtask : t_xfer
   task automatic t_table();
      apb_xfer(1'b0, 10'h01c, 32'h0);
      `CHK("ptr reset", 32'h0, r)
      apb_xfer(1'b1, 10'h01c, 32'h37);
      apb_xfer(1'b0, 10'h01c, 32'h0);
      `CHK("ptr", 32'h37, r)
      for (int i = 0; i < 2; i++) begin
         step(i ? ps_pkg::OP_TRDL : ps_pkg::OP_TRDC, 13'h0);
         a = i ? 10'h337 : {pre[9:8], 8'h37};
         w = wd(a);
         `CHK("table addr", a, ra)
         `CHK("table cycle", 1'b0, ivalid)
         step(ps_pkg::OP_NONE, 13'h0);
         `CHK("table strobe", 1'b1, twr)
         `CHK("table low", w[7:0], tdata)
         apb_xfer(1'b0, 10'h020, 32'h0);
         `CHK("table high", 32'(w[15:8]), r)
      end
      apb_xfer(1'b0, 10'h03c, 32'h0);
      `CHK("unmapped err", 1'b1, e)
   endtask : t_table
   task automatic t_short_jump();
      apb_xfer(1'b1, 10'h018, 32'h40);
      step(ps_pkg::OP_NONE, 13'h0);
      a = {pre[9:8], 8'h40};
      `CHK("short jump", a, ra)
   endtask : t_short_jump
   task automatic t_irq();
      apb_xfer(1'b1, 10'h024, 32'h7);
      @(posedge clk);
      ext_n <= 1'b0;
      t0 <= 1'b1;
      @(posedge clk);
      t0 <= 1'b0;
      wait_ack();
      `CHK("ext vector", 10'h004, ra)
      wait_ack();
      `CHK("ack spacing", 4, n)
      `CHK("t0 vector", 10'h008, ra)
      @(posedge clk);
      t1 <= 1'b1;
      ext_n <= 1'b1;
      @(posedge clk);
      t1 <= 1'b0;
      wait_ack();
      `CHK("held ack", 40, n)
      step(ps_pkg::OP_SUB_RET, 13'h0);
      wait_ack();
      `CHK("t1 vector", 10'h00c, ra)
      step(ps_pkg::OP_NONE, 13'h0);
      step(ps_pkg::OP_CALL, 13'h01f0);
      a = pre;
      step(ps_pkg::OP_NONE, 13'h0);
      step(ps_pkg::OP_SUB_RET, 13'h0);
      `CHK("full call ret", a, ra)
      step(ps_pkg::OP_NONE, 13'h0);
      step(ps_pkg::OP_INT_RET, 13'h0);
      `CHK("oldest lost", 10'h004, ra)
   endtask : t_irq
   initial begin
      repeat (15) @(posedge clk);
      @(negedge clk);
      `CHK("reset addr", 10'h000, ra)
      `CHK("reset phase", 4'h1, phase)
      @(posedge clk);
      rst <= 1'b0;
      step(ps_pkg::OP_NONE, 13'h0);
      `CHK("first word", wd(10'h000), instr)
      t_seq();
      t_xfer();
      t_table();
      t_short_jump();
      t_irq();
      results();
   end
   initial begin
      repeat (5000) @(posedge clk);
      bad_count++;
      results();
   end
endmodule : tb
